// ---- tbfmc_pkg.sv ----
package tbfmc_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses on APB)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_MODEM_CONFIG_TWO = 8'h00;
  localparam logic [7:0] ADDR_DEVIATION_CONFIG = 8'h04;
  localparam logic [7:0] ADDR_TX_DATA = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_DEV_WORD = 8'h10;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int MOD_FMT_LSB = 0;
  localparam int MANCH_BIT = 3;
  localparam int FEC_BIT = 4;
  localparam int WHITE_BIT = 5;
  localparam int DEV_M_LSB = 0;
  localparam int DEV_E_LSB = 4;
  localparam int TXD_HDR_BIT = 8;
  localparam int TXD_LAST_BIT = 9;
  localparam int ST_FULL_BIT = 0;
  localparam int ST_BUSY_BIT = 1;
  localparam int ST_PAD_BIT = 2;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [5:0] MODEM_CONFIG_TWO_RST = 6'h00;
  localparam logic [2:0] DEV_M_RST = 3'h7;
  localparam logic [2:0] DEV_E_RST = 3'h4;

  // ----------------------------------------------------------------
  // Modulation format codes
  // ----------------------------------------------------------------
  localparam logic [2:0] FMT_FSK2 = 3'h0;
  localparam logic [2:0] FMT_GFSK = 3'h1;
  localparam logic [2:0] FMT_OOK = 3'h3;
  localparam logic [2:0] FMT_MSK = 3'h7;

  // ----------------------------------------------------------------
  // Coding constants
  // ----------------------------------------------------------------
  localparam logic [3:0] CONV_POLY_A = 4'hf;
  localparam logic [3:0] CONV_POLY_B = 4'hb;
  localparam logic [7:0] PAD_BYTE = 8'h00;
  localparam logic [8:0] PN9_SEED = 9'h1ff;
  localparam logic [3:0] DEV_BASE = 4'h8;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 10000000;
  localparam int SYM_BAUD = 500000;
  localparam int SYM_CYCLES = CLK_HZ / SYM_BAUD;

endpackage

// ---- tbfmc_fec.sv ----
`timescale 1ns/100ps

module tbfmc_fec (
  input wire logic [7:0] i_byte,
  input wire logic [2:0] i_state,
  output logic [15:0] o_chunk,
  output logic [2:0] o_state
);

  // ----------------------------------------------------------------
  // Convolutional coder, one byte MSB first, two bits per input bit
  // ----------------------------------------------------------------
  logic [15:0] coded;

  always_comb begin
    logic [2:0] s;
    logic [3:0] r;
    s = i_state;
    r = 4'h0;
    coded = 16'h0000;
    for (int k = 0; k < 8; k++) begin
      r = {i_byte[7-k], s};
      coded[15-2*k] = ^(r & tbfmc_pkg::CONV_POLY_A);
      coded[14-2*k] = ^(r & tbfmc_pkg::CONV_POLY_B);
      s = {i_byte[7-k], s[2:1]};
    end
    o_state = s;
  end

  // ----------------------------------------------------------------
  // 4x4 matrix: rows written in order, columns read out
  // ----------------------------------------------------------------
  genvar gr, gc;
  generate
    for (gc = 0; gc < 4; gc++) begin : g_col
      for (gr = 0; gr < 4; gr++) begin : g_row
        assign o_chunk[15-(4*gc+gr)] = coded[15-(4*gr+gc)];
      end
    end
  endgenerate

endmodule // tbfmc_fec

// ---- tbfmc_top.sv ----
// Our own choices: the address map and register access over APB.
`timescale 1ns/100ps

module tbfmc_top (
  input wire logic I_CLOCK,
  input wire logic I_RST,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  output logic O_SYM_TICK,
  output logic O_FREQ_UP,
  output logic O_PA_ON,
  output logic O_GAUSS_EN,
  output logic O_MSK_MODE,
  output logic [2:0] O_MSK_FRAC,
  output logic [10:0] O_DEV_WORD
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Whitening of one byte, MSB first; returns {next state, data}
  function automatic logic [16:0] pn9_byte(input logic [7:0] d,
                                           input logic [8:0] st);
    logic [8:0] s;
    logic [7:0] o;
    s = st;
    o = 8'h00;
    for (int k = 0; k < 8; k++) begin
      o[7-k] = d[7-k] ^ s[0];
      s = {s[0] ^ s[5], s[8:1]};
    end
    return {s, o};
  endfunction

  // Manchester expansion: one as 10, zero as 01
  function automatic logic [15:0] manch_byte(input logic [7:0] d);
    logic [15:0] o;
    o = 16'h0000;
    for (int k = 0; k < 8; k++) begin
      o[15-2*k] = d[7-k];
      o[14-2*k] = ~d[7-k];
    end
    return o;
  endfunction

  // Address match for an APB access phase
  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    return a == b;
  endfunction

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic [2:0] mod_fmt_r;
  logic manch_en_r;
  logic error_correction_enable_r;
  logic white_en_r;
  logic [2:0] dev_m_r;
  logic [2:0] dev_e_r;
  logic apb_wr;
  logic apb_rd;

  assign apb_wr = I_PSEL & I_PENABLE & I_PWRITE;
  assign apb_rd = I_PSEL & I_PENABLE & ~I_PWRITE;

  // Modem configuration write
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      {white_en_r, error_correction_enable_r, manch_en_r, mod_fmt_r} <=
        tbfmc_pkg::MODEM_CONFIG_TWO_RST;
    end else if (apb_wr && hit(I_PADDR,
                               tbfmc_pkg::ADDR_MODEM_CONFIG_TWO)) begin
      mod_fmt_r <= I_PWDATA[tbfmc_pkg::MOD_FMT_LSB +: 3];
      manch_en_r <= I_PWDATA[tbfmc_pkg::MANCH_BIT];
      error_correction_enable_r <= I_PWDATA[tbfmc_pkg::FEC_BIT];
      white_en_r <= I_PWDATA[tbfmc_pkg::WHITE_BIT];
    end
  end

  // Deviation configuration write
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      dev_m_r <= tbfmc_pkg::DEV_M_RST;
      dev_e_r <= tbfmc_pkg::DEV_E_RST;
    end else if (apb_wr && hit(I_PADDR,
                               tbfmc_pkg::ADDR_DEVIATION_CONFIG)) begin
      dev_m_r <= I_PWDATA[tbfmc_pkg::DEV_M_LSB +: 3];
      dev_e_r <= I_PWDATA[tbfmc_pkg::DEV_E_LSB +: 3];
    end
  end

  // ----------------------------------------------------------------
  // Deviation word, in units of crystal frequency over 2^17
  // ----------------------------------------------------------------
  logic [10:0] dev_word_nxt;

  assign dev_word_nxt = 11'({tbfmc_pkg::DEV_BASE + {1'b0, dev_m_r}})
                        << dev_e_r;

  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      O_DEV_WORD <= 11'h000;
    end else begin
      O_DEV_WORD <= dev_word_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Byte holding register fed from the bus
  // ----------------------------------------------------------------
  logic hold_v_r;
  logic [7:0] hold_d_r;
  logic hold_hdr_r;
  logic hold_last_r;
  logic take_hold;
  logic txd_wr;

  assign txd_wr = apb_wr && hit(I_PADDR, tbfmc_pkg::ADDR_TX_DATA);

  // A write while full is dropped unless the held byte is taken in the same cycle; status shows full
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      hold_v_r <= 1'b0;
      hold_d_r <= 8'h00;
      hold_hdr_r <= 1'b0;
      hold_last_r <= 1'b0;
    end else if (txd_wr && (!hold_v_r || take_hold)) begin
      hold_v_r <= 1'b1;
      hold_d_r <= I_PWDATA[7:0];
      hold_hdr_r <= I_PWDATA[tbfmc_pkg::TXD_HDR_BIT];
      hold_last_r <= I_PWDATA[tbfmc_pkg::TXD_LAST_BIT];
    end else if (take_hold) begin
      hold_v_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Symbol rate enable
  // ----------------------------------------------------------------
  logic [7:0] div_r;
  logic tick;

  assign tick = div_r == 8'((tbfmc_pkg::SYM_CYCLES) - 1);

  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      div_r <= 8'h00;
    end else if (tick) begin
      div_r <= 8'h00;
    end else begin
      div_r <= div_r + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Source selection: pad bytes take priority over new bytes
  // ----------------------------------------------------------------
  logic [1:0] pad_left_r;
  logic [4:0] cnt_r;
  logic src_v;
  logic src_pad;
  logic [7:0] src_byte;
  logic src_hdr;
  logic load;

  assign src_pad = pad_left_r != 2'd0;
  assign src_v = src_pad | hold_v_r;
  assign src_byte = src_pad ? tbfmc_pkg::PAD_BYTE : hold_d_r;
  assign src_hdr = src_pad ? 1'b0 : hold_hdr_r;
  assign load = src_v && (cnt_r == 5'd0);
  assign take_hold = load && !src_pad;

  // ----------------------------------------------------------------
  // Whitening and coding of the selected byte
  // ----------------------------------------------------------------
  logic [8:0] pn9_r;
  logic [2:0] enc_r;
  logic [16:0] wh;
  logic [7:0] coded_in;
  logic [15:0] fec_chunk;
  logic [2:0] enc_nxt;
  logic use_fec;
  logic use_manch;
  logic [15:0] chunk;
  logic [4:0] chunk_len;

  assign wh = pn9_byte(src_byte, pn9_r);
  // Whitening comes first, only past the sync word
  assign coded_in = (white_en_r && !src_hdr) ? wh[7:0] : src_byte;
  assign use_fec = error_correction_enable_r && !src_hdr;
  // Manchester is not applied with FEC on
  assign use_manch = manch_en_r && !error_correction_enable_r;

  tbfmc_fec u_fec (
    .i_byte(coded_in),
    .i_state(enc_r),
    .o_chunk(fec_chunk),
    .o_state(enc_nxt)
  );

  // Channel bits for one source byte
  always_comb begin
    if (use_fec) begin
      chunk = fec_chunk;
      chunk_len = 5'd16;
    end else if (use_manch) begin
      chunk = manch_byte(coded_in);
      chunk_len = 5'd16;
    end else begin
      chunk = {coded_in, 8'h00};
      chunk_len = 5'd8;
    end
  end

  // Whitening and coder state, restarted by header bytes
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      pn9_r <= tbfmc_pkg::PN9_SEED;
      enc_r <= 3'h0;
    end else if (load && src_hdr) begin
      pn9_r <= tbfmc_pkg::PN9_SEED;
      enc_r <= 3'h0;
    end else if (load) begin
      pn9_r <= white_en_r ? wh[16:8] : pn9_r;
      enc_r <= use_fec ? enc_nxt : enc_r;
    end
  end

  // ----------------------------------------------------------------
  // Padding after the last payload byte
  // ----------------------------------------------------------------
  logic odd_r;

  // Parity of payload bytes loaded so far in this packet
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      odd_r <= 1'b0;
    end else if (load && src_hdr) begin
      odd_r <= 1'b0;
    end else if (load && !src_pad) begin
      odd_r <= ~odd_r;
    end
  end

  // Parity excludes the last byte: even before it means odd total, one pad
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      pad_left_r <= 2'd0;
    end else if (load && src_pad) begin
      pad_left_r <= pad_left_r - 2'd1;
    end else if (take_hold && hold_last_r && use_fec) begin
      pad_left_r <= odd_r ? 2'd2 : 2'd1;
    end
  end

  // ----------------------------------------------------------------
  // Serialiser; alternating idle pattern when starved
  // ----------------------------------------------------------------
  logic [15:0] sh_r;
  logic idle_r;
  logic bit_now;

  always_comb begin
    if (cnt_r != 5'd0) begin
      bit_now = sh_r[15];
    end else if (load) begin
      bit_now = chunk[15];
    end else begin
      bit_now = idle_r;
    end
  end

  // Shift one channel bit per symbol enable
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      sh_r <= 16'h0000;
      cnt_r <= 5'd0;
    end else if (load && tick) begin
      sh_r <= {chunk[14:0], 1'b0};
      cnt_r <= chunk_len - 5'd1;
    end else if (load) begin
      sh_r <= chunk;
      cnt_r <= chunk_len;
    end else if (tick && cnt_r != 5'd0) begin
      sh_r <= {sh_r[14:0], 1'b0};
      cnt_r <= cnt_r - 5'd1;
    end
  end

  // Idle pattern toggles on each starved symbol
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      idle_r <= 1'b1;
    end else if (tick && cnt_r == 5'd0 && !load) begin
      idle_r <= ~idle_r;
    end
  end

  // ----------------------------------------------------------------
  // Modulator controls
  // ----------------------------------------------------------------
  logic is_msk;
  logic is_ook;

  assign is_msk = mod_fmt_r == tbfmc_pkg::FMT_MSK;
  assign is_ook = mod_fmt_r == tbfmc_pkg::FMT_OOK;

  // Symbol level and amplifier gate, updated once per symbol
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      O_FREQ_UP <= 1'b0;
      O_PA_ON <= 1'b0;
    end else if (tick) begin
      // Every bit inverted in MSK, preamble included
      O_FREQ_UP <= is_msk ? ~bit_now : bit_now;
      O_PA_ON <= is_ook ? bit_now : 1'b1;
    end
  end

  // Static shaping selections and the registered symbol tick
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      O_GAUSS_EN <= 1'b0;
      O_MSK_MODE <= 1'b0;
      O_MSK_FRAC <= 3'h0;
      O_SYM_TICK <= 1'b0;
    end else begin
      O_GAUSS_EN <= mod_fmt_r == tbfmc_pkg::FMT_GFSK;
      O_MSK_MODE <= is_msk;
      O_MSK_FRAC <= is_msk ? dev_m_r : 3'h0;
      O_SYM_TICK <= tick;
    end
  end

  // ----------------------------------------------------------------
  // APB read and answer
  // ----------------------------------------------------------------
  logic mapped;

  assign mapped = hit(I_PADDR, tbfmc_pkg::ADDR_MODEM_CONFIG_TWO) ||
                  hit(I_PADDR, tbfmc_pkg::ADDR_DEVIATION_CONFIG) ||
                  hit(I_PADDR, tbfmc_pkg::ADDR_TX_DATA) ||
                  hit(I_PADDR, tbfmc_pkg::ADDR_STATUS) ||
                  hit(I_PADDR, tbfmc_pkg::ADDR_DEV_WORD);
  assign O_PREADY = I_PSEL & I_PENABLE;
  assign O_PSLVERR = I_PSEL & I_PENABLE & ~mapped;

  // Read data mux
  always_comb begin
    O_PRDATA = 32'h00000000;
    if (apb_rd) begin
      case (I_PADDR)
        tbfmc_pkg::ADDR_MODEM_CONFIG_TWO: begin
          O_PRDATA[5:0] = {white_en_r, error_correction_enable_r, manch_en_r, mod_fmt_r};
        end
        tbfmc_pkg::ADDR_DEVIATION_CONFIG: begin
          O_PRDATA[6:0] = {dev_e_r, 1'b0, dev_m_r};
        end
        tbfmc_pkg::ADDR_STATUS: begin
          O_PRDATA[tbfmc_pkg::ST_FULL_BIT] = hold_v_r;
          O_PRDATA[tbfmc_pkg::ST_BUSY_BIT] = cnt_r != 5'd0;
          O_PRDATA[tbfmc_pkg::ST_PAD_BIT] = src_pad;
        end
        tbfmc_pkg::ADDR_DEV_WORD: begin
          O_PRDATA[10:0] = O_DEV_WORD;
        end
        default: begin
          O_PRDATA = 32'h00000000;
        end
      endcase
    end
  end

endmodule // tbfmc_top

// ---- tbfmc_checker.sv ----
`timescale 1ns/100ps
// ---
// Port checker
// ---
module tbfmc_checker (
  input wire logic I_CLOCK,
  input wire logic I_RST,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic [31:0] O_PRDATA,
  input wire logic O_PREADY,
  input wire logic O_PSLVERR,
  input wire logic O_SYM_TICK,
  input wire logic O_FREQ_UP,
  input wire logic O_PA_ON,
  input wire logic O_GAUSS_EN,
  input wire logic O_MSK_MODE,
  input wire logic [2:0] O_MSK_FRAC,
  input wire logic [10:0] O_DEV_WORD
);
  logic acc;
  logic mapped;
  logic seen_r;
  logic [4:0] gap_r;
  logic [10:0] dev_r;
  logic [2:0] fmt_r;
  // Access phase and address decode
  assign acc = I_PSEL && I_PENABLE;
  assign mapped = I_PADDR[1:0] == 2'h0 && I_PADDR <= tbfmc_pkg::ADDR_DEV_WORD;
  // Cycles since the last symbol tick
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      gap_r <= 5'h00;
      seen_r <= 1'b0;
    end else if (O_SYM_TICK) begin
      gap_r <= 5'h00;
      seen_r <= 1'b1;
    end else begin
      gap_r <= gap_r + 5'h01;
    end
  end
  // Last written deviation word and format
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      dev_r <= 11'h0f0;
      fmt_r <= 3'h0;
    end else if (acc && I_PWRITE) begin
      if (I_PADDR == tbfmc_pkg::ADDR_DEVIATION_CONFIG) begin
        dev_r <= (11'h008 + 11'(I_PWDATA[2:0])) << I_PWDATA[6:4];
      end
      if (I_PADDR == tbfmc_pkg::ADDR_MODEM_CONFIG_TWO) begin
        fmt_r <= I_PWDATA[2:0];
      end
    end
  end
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (I_RST);
  sequence dev_wr_s;
    acc && I_PWRITE && I_PADDR == tbfmc_pkg::ADDR_DEVIATION_CONFIG;
  endsequence
  sequence cfg_wr_s;
    acc && I_PWRITE && I_PADDR == tbfmc_pkg::ADDR_MODEM_CONFIG_TWO;
  endsequence
  ready_in_access_a: assert property (O_PREADY == acc)
    else $error("ready not tied to access phase");
  unmapped_err_a: assert property (acc && !mapped |->
    O_PSLVERR && O_PRDATA == 32'h0)
    else $error("unmapped access without error");
  bus_quiet_a: assert property (!acc |-> O_PRDATA == 32'h0 && !O_PSLVERR)
    else $error("read data or error outside access");
  tick_period_a: assert property (O_SYM_TICK && seen_r |-> gap_r == 5'h13)
    else $error("symbol tick period wrong");
  tick_pulse_a: assert property (O_SYM_TICK |=> !O_SYM_TICK)
    else $error("symbol tick longer than one cycle");
  symbol_hold_a: assert property (!O_SYM_TICK |-> $stable(O_FREQ_UP))
    else $error("frequency level moved between ticks");
  dev_word_a: assert property (dev_wr_s |-> ##2 O_DEV_WORD == dev_r)
    else $error("deviation word wrong");
  format_out_a: assert property (cfg_wr_s |-> ##2
    (O_MSK_MODE == (fmt_r == tbfmc_pkg::FMT_MSK) &&
     O_GAUSS_EN == (fmt_r == tbfmc_pkg::FMT_GFSK)))
    else $error("format outputs wrong");
  frac_zero_a: assert property (!O_MSK_MODE |-> O_MSK_FRAC == 3'h0)
    else $error("phase fraction outside shift keying");
  pa_steady_a: assert property (
    O_MSK_MODE && $past(O_MSK_MODE, 30) |-> O_PA_ON)
    else $error("amplifier off outside on-off keying");
endmodule // tbfmc_checker

bind tbfmc_top tbfmc_checker u_chk (.I_CLOCK(I_CLOCK), .I_RST(I_RST),
  .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE),
  .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA),
  .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .O_SYM_TICK(O_SYM_TICK),
  .O_FREQ_UP(O_FREQ_UP), .O_PA_ON(O_PA_ON), .O_GAUSS_EN(O_GAUSS_EN),
  .O_MSK_MODE(O_MSK_MODE), .O_MSK_FRAC(O_MSK_FRAC),
  .O_DEV_WORD(O_DEV_WORD));

// ---- tbfmc_rx_model.sv ----
`timescale 1ns/100ps
// ---
// Remote receiver, one entry per symbol
// ---
module tbfmc_rx_model (
  input wire logic i_clk,
  input wire logic i_tick,
  input wire logic i_freq,
  input wire logic i_pa
);
  logic [1:0] sym_q[$];
  // Capture amplifier and frequency level at each symbol
  always @(posedge i_clk) begin
    if (i_tick === 1'b1) begin
      sym_q.push_back({i_pa, i_freq});
    end
  end
endmodule // tbfmc_rx_model

// ---- testbench.sv ----
`timescale 1ns/100ps
// ---
// Self-checking bench
// ---
module testbench;
  localparam logic [7:0] AMC = tbfmc_pkg::ADDR_MODEM_CONFIG_TWO;
  localparam logic [7:0] ADV = tbfmc_pkg::ADDR_DEVIATION_CONFIG;
  localparam logic [7:0] ATX = tbfmc_pkg::ADDR_TX_DATA;
  localparam logic [7:0] AST = tbfmc_pkg::ADDR_STATUS;
  localparam logic [7:0] ADW = tbfmc_pkg::ADDR_DEV_WORD;
  logic clk, rst, psel, pen, pwr, erv;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, v;
  logic pready, pslverr, tick, fup, pa, gauss, msk;
  logic [2:0] frac, cst;
  logic [10:0] devw;
  logic exp_q[$];
  logic [6:0] dv[3] = '{7'h00, 7'h77, 7'h12};
  logic [5:0] cf[5] = '{6'h00, 6'h21, 6'h08, 6'h07, 6'h03};
  logic [9:0] tx[5] = '{10'h0a5, 10'h13c, 10'h0c3, 10'h096, 10'h05a};
  int n_errors, total_checks, cyc, snap;

  tbfmc_top uut (.I_CLOCK(clk), .I_RST(rst), .I_PSEL(psel),
    .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata),
    .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
    .O_SYM_TICK(tick), .O_FREQ_UP(fup), .O_PA_ON(pa), .O_GAUSS_EN(gauss),
    .O_MSK_MODE(msk), .O_MSK_FRAC(frac), .O_DEV_WORD(devw));
  tbfmc_rx_model rx (.i_clk(clk), .i_tick(tick), .i_freq(fup), .i_pa(pa));

  // Clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Compare and count
  task chk(input logic [31:0] seen, input logic [31:0] want);
    total_checks++;
    if (seen !== want) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, want);
    end
  endtask

  // Verdict
  task end_of_test;
    $display("checks=%0d errors=%0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // One APB transfer, setup then access until ready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    erv = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task rchk(input logic [7:0] a, input logic [31:0] want);
    apb(1'b0, a, 32'h0);
    chk(rd, want);
  endtask

  // Write a TX word once the holding register has room
  task send(input logic [9:0] d);
    apb(1'b0, AST, 32'h0);
    while (rd[0] !== 1'b0) apb(1'b0, AST, 32'h0);
    apb(1'b1, ATX, {22'h0, d});
  endtask

  // Start of a packet in the captured stream
  task mark;
    @(posedge clk);
    @(negedge clk);
    snap = rx.sym_q.size();
  endtask

  // Plain or Manchester expected symbols, MSB first
  task pb(input logic [7:0] b, input logic man);
    for (int i = 7; i >= 0; i--) begin
      exp_q.push_back(b[i]);
      if (man) exp_q.push_back(!b[i]);
    end
  endtask

  // Coded and interleaved expected symbols
  task pf(input logic [7:0] b);
    logic [15:0] c;
    logic [3:0] w;
    for (int i = 7; i >= 0; i--) begin
      w = {b[i], cst};
      c[14-2*i] = ^(w & tbfmc_pkg::CONV_POLY_A);
      c[15-2*i] = ^(w & tbfmc_pkg::CONV_POLY_B);
      cst = {b[i], cst[2:1]};
    end
    for (int k = 0; k < 16; k++) exp_q.push_back(c[(k%4)*4+k/4]);
  endtask

  // Compare stream: 0 frequency, 1 inverted frequency, 2 amplifier
  task cmp(input int m);
    logic [1:0] s;
    logic g;
    while (rx.sym_q.size() < snap + exp_q.size()) @(posedge clk);
    foreach (exp_q[k]) begin
      s = rx.sym_q[snap+k];
      g = (m == 2) ? s[1] : (s[0] ^ (m == 1));
      chk({31'h0, g}, {31'h0, exp_q[k]});
    end
    exp_q.delete();
  endtask

  // Hang limit
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_errors++;
      end_of_test();
    end
  end

  // Main sequence
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rchk(AMC, 32'h0);
    rchk(ADV, 32'h47);
    rchk(ADW, 32'hf0);
    rchk(ATX, 32'h0);
    rchk(8'h14, 32'h0);
    chk({31'h0, erv}, 32'h1);
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, ADV, {25'h0, dv[i]});
      v = (32'h8 + {29'h0, dv[i][2:0]}) << dv[i][6:4];
      rchk(ADW, v);
      chk({21'h0, devw}, v);
    end
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, AMC, {26'h0, cf[i]});
      repeat (3) @(posedge clk);
      chk({31'h0, gauss}, 32'(i == 1));
      chk({31'h0, msk}, 32'(i == 3));
      chk({29'h0, frac}, (i == 3) ? 32'h2 : 32'h0);
      send(tx[i]);
      mark();
      pb(tx[i][7:0], i == 2);
      // Payload after the header is whitened from an all-ones seed
      if (i == 1) begin
        send(10'h033);
        pb(8'hcc, 1'b0);
      end
      cmp((i == 3) ? 1 : ((i == 4) ? 2 : 0));
    end
    apb(1'b1, AMC, 32'h10);
    cst = 3'h0;
    send(10'h13c);
    mark();
    pb(8'h3c, 1'b0);
    send(10'h0e1);
    apb(1'b0, AST, 32'h0);
    chk(rd & 32'h3, 32'h3);
    pf(8'he1);
    send(10'h04b);
    pf(8'h4b);
    send(10'h2d2);
    pf(8'hd2);
    pf(tbfmc_pkg::PAD_BYTE);
    cmp(0);
    cst = 3'h0;
    send(10'h1aa);
    mark();
    pb(8'haa, 1'b0);
    send(10'h012);
    pf(8'h12);
    send(10'h234);
    pf(8'h34);
    pf(tbfmc_pkg::PAD_BYTE);
    pf(tbfmc_pkg::PAD_BYTE);
    cmp(0);
    end_of_test();
  end
endmodule // testbench
